// ==== nvac_cfg.svh ====
// Register offsets, field positions, unlock codes, masks and timing counts for the access controller.
// Assumes one instruction cycle per core_clk cycle.
`ifndef NVAC_CFG_SVH
`define NVAC_CFG_SVH
`define NVAC_OFF_ACCESS_CONTROL 9'h18c
`define NVAC_OFF_UNLOCK_PORT    9'h18d
`define NVAC_OFF_DATA_LOW       9'h10c
`define NVAC_OFF_ADDR_LOW       9'h10d
`define NVAC_OFF_DATA_HIGH      9'h10e
`define NVAC_OFF_ADDR_HIGH      9'h10f
`define NVAC_OFF_STATUS         9'h10b
`define NVAC_BIT_SPACE          7
`define NVAC_BIT_ABORT          3
`define NVAC_BIT_PERMIT         2
`define NVAC_BIT_WRITE          1
`define NVAC_BIT_READ           0
`define NVAC_BIT_DONE           0
`define NVAC_UNLOCK_FIRST       8'h55
`define NVAC_UNLOCK_SECOND      8'haa
`define NVAC_FLASH_RD_CYCLES    2'h2
`define NVAC_FLASH_WR_CYCLES    2'h2
`define NVAC_EE_WR_CYCLES       16'h0100
`define NVAC_CNT_ONE            16'h0001
`define NVAC_ADDR_HI_MASK       8'h1f
`define NVAC_DATA_HI_MASK       8'h3f
`define NVAC_ZERO8              8'h00
`endif

// ==== nvac_pkg.sv ====
// Types shared by the access controller: states and the register-file state record.
// Assumes the constants header is included by the design file.
package nvac_pkg;
  typedef enum logic [2:0] {
    NVAC_IDLE, NVAC_FRD, NVAC_EEWR, NVAC_FLWR
  } nvac_state_t;
  typedef enum logic [1:0] {
    NVAC_LOCK0, NVAC_LOCK1, NVAC_LOCK2
  } nvac_unlock_t;
  typedef struct packed {
    nvac_state_t  st;
    nvac_unlock_t ul;
    logic [15:0]  cnt;
    logic         space;
    logic         abort;
    logic         permit;
    logic         wr;
    logic         rd;
    logic         done;
    logic [7:0]   addr_lo;
    logic [7:0]   addr_hi;
    logic [7:0]   data_lo;
    logic [7:0]   data_hi;
    logic [7:0]   rdata;
    logic         stall;
    logic         mem_we;
    logic         mem_space;
    logic [12:0]  mem_addr;
    logic [13:0]  mem_wdata;
    logic [2:0]   warm_sync;
    logic         warm;
  } nvac_state_rec_t;
endpackage

// ==== nvac_ctrl.sv ====
// Data EEPROM / program flash access controller with its register file.
// Assumes the processor runs one instruction per core_clk and honours cpu_stall.
// Assumes abort_rst may come from another clock; it is filtered in here.
`timescale 1ns/1ps
`include "nvac_cfg.svh"
module nvac_ctrl #(
  parameter logic [15:0] EE_WR_CYCLES = `NVAC_EE_WR_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        abort_rst,
  input  wire logic [8:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        flash_store_permit_cfg,
  input  wire logic        flash_protected,
  input  wire logic [7:0]  ee_rdata,
  input  wire logic [13:0] fl_rdata,
  output logic             mem_we,
  output logic             mem_space,
  output logic      [12:0] mem_addr,
  output logic      [13:0] mem_wdata,
  output logic             cpu_stall
);

  nvac_pkg::nvac_state_rec_t s_r;
  nvac_pkg::nvac_state_rec_t s_nxt;

  // Address decode used by both the write and the read path
  function automatic logic hit(input logic [8:0] a, input logic [8:0] off);
    hit = (a == off);
  endfunction

  // Control register image; unimplemented bits forced to zero
  function automatic logic [7:0] ctl_image(input nvac_pkg::nvac_state_rec_t s);
    ctl_image = `NVAC_ZERO8;
    ctl_image[`NVAC_BIT_SPACE]  = s.space;
    ctl_image[`NVAC_BIT_ABORT]  = s.abort;
    ctl_image[`NVAC_BIT_PERMIT] = s.permit;
    ctl_image[`NVAC_BIT_WRITE]  = s.wr;
    ctl_image[`NVAC_BIT_READ]   = s.rd;
  endfunction

  logic wr_ctl;
  logic busy;
  logic go_wr;
  logic go_rd;
  logic fl_ok;
  logic warm_hit;

  // Next-state logic: register writes, unlock tracking, and the access engine
  always_comb begin
    s_nxt        = s_r;
    s_nxt.mem_we = 1'b0;
    // Warm reset crosses clocks: three flops, a change counts once the last two agree
    s_nxt.warm_sync = {s_r.warm_sync[1:0], abort_rst};
    warm_hit        = (s_r.warm_sync[1] == s_r.warm_sync[2]) ? s_r.warm_sync[2] : s_r.warm;
    s_nxt.warm      = warm_hit;
    wr_ctl       = reg_wr && hit(reg_addr, `NVAC_OFF_ACCESS_CONTROL);
    busy         = (s_r.st != nvac_pkg::NVAC_IDLE) || s_r.rd || s_r.wr;
    // Flash writes gated by protection and the configuration permit
    fl_ok        = flash_store_permit_cfg && !flash_protected;
    // Permit must already be set from an earlier write; the new value does not count
    go_wr = wr_ctl && reg_wdata[`NVAC_BIT_WRITE] && !busy && s_r.permit
            && (s_r.ul == nvac_pkg::NVAC_LOCK2)
            && (!s_r.space || fl_ok);
    go_rd = wr_ctl && reg_wdata[`NVAC_BIT_READ] && !busy && !go_wr;

    // Unlock sequence: any other bus write breaks it
    if (reg_wr) begin
      if (hit(reg_addr, `NVAC_OFF_UNLOCK_PORT) && reg_wdata == `NVAC_UNLOCK_FIRST) begin
        s_nxt.ul = nvac_pkg::NVAC_LOCK1;
      end else if (hit(reg_addr, `NVAC_OFF_UNLOCK_PORT) && reg_wdata == `NVAC_UNLOCK_SECOND
                   && s_r.ul == nvac_pkg::NVAC_LOCK1) begin
        s_nxt.ul = nvac_pkg::NVAC_LOCK2;
      end else begin
        s_nxt.ul = nvac_pkg::NVAC_LOCK0;
      end
    end

    // Plain register writes
    if (wr_ctl) begin
      s_nxt.permit = reg_wdata[`NVAC_BIT_PERMIT];
      s_nxt.abort  = reg_wdata[`NVAC_BIT_ABORT];
      if (!busy) begin
        s_nxt.space = reg_wdata[`NVAC_BIT_SPACE];
      end
    end
    if (reg_wr && hit(reg_addr, `NVAC_OFF_ADDR_LOW)) begin
      s_nxt.addr_lo = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `NVAC_OFF_ADDR_HIGH)) begin
      s_nxt.addr_hi = reg_wdata & `NVAC_ADDR_HI_MASK;
    end
    if (reg_wr && hit(reg_addr, `NVAC_OFF_DATA_LOW)) begin
      s_nxt.data_lo = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `NVAC_OFF_DATA_HIGH)) begin
      s_nxt.data_hi = reg_wdata & `NVAC_DATA_HI_MASK;
    end
    // Done flag: software writes zero to clear, completion below wins
    if (reg_wr && hit(reg_addr, `NVAC_OFF_STATUS) && !reg_wdata[`NVAC_BIT_DONE]) begin
      s_nxt.done = 1'b0;
    end

    // Access engine
    unique case (s_r.st)
      nvac_pkg::NVAC_IDLE: begin
        if (go_rd && !s_r.space) begin
          // EEPROM read completes at once; data visible next cycle
          s_nxt.data_lo = ee_rdata;
          s_nxt.rd      = 1'b0;
        end else if (go_rd) begin
          s_nxt.rd  = 1'b1;
          s_nxt.st  = nvac_pkg::NVAC_FRD;
          s_nxt.cnt = `NVAC_CNT_ONE;
        end else if (go_wr) begin
          s_nxt.wr        = 1'b1;
          s_nxt.ul        = nvac_pkg::NVAC_LOCK0;
          s_nxt.mem_space = s_r.space;
          s_nxt.mem_addr  = {s_r.addr_hi[4:0], s_r.addr_lo};
          s_nxt.mem_wdata = s_r.space ? {s_r.data_hi[5:0], s_r.data_lo}
                                      : {6'h00, s_r.data_lo};
          if (s_r.space) begin
            s_nxt.st    = nvac_pkg::NVAC_FLWR;
            s_nxt.stall = 1'b1;
            s_nxt.cnt   = `NVAC_CNT_ONE;
          end else begin
            s_nxt.st  = nvac_pkg::NVAC_EEWR;
            s_nxt.cnt = `NVAC_CNT_ONE;
          end
        end
      end
      nvac_pkg::NVAC_FRD: begin
        // Two fetch cycles, then the word lands in both data registers
        if (s_r.cnt[1:0] == `NVAC_FLASH_RD_CYCLES) begin
          s_nxt.data_lo = fl_rdata[7:0];
          s_nxt.data_hi = {2'h0, fl_rdata[13:8]};
          s_nxt.rd      = 1'b0;
          s_nxt.st      = nvac_pkg::NVAC_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt + `NVAC_CNT_ONE;
        end
      end
      nvac_pkg::NVAC_EEWR: begin
        // Self-timed; trigger stays high throughout
        if (s_r.cnt == EE_WR_CYCLES) begin
          s_nxt.mem_we = 1'b1;
          s_nxt.wr     = 1'b0;
          s_nxt.done   = 1'b1;
          s_nxt.abort  = 1'b0;
          s_nxt.st     = nvac_pkg::NVAC_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt + `NVAC_CNT_ONE;
        end
      end
      nvac_pkg::NVAC_FLWR: begin
        // Processor held for two cycles while the word is stored
        if (s_r.cnt[1:0] == `NVAC_FLASH_WR_CYCLES) begin
          s_nxt.mem_we = 1'b1;
          s_nxt.stall  = 1'b0;
          s_nxt.wr     = 1'b0;
          s_nxt.done   = 1'b1;
          s_nxt.abort  = 1'b0;
          s_nxt.st     = nvac_pkg::NVAC_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt + `NVAC_CNT_ONE;
        end
      end
      default: s_nxt.st = nvac_pkg::NVAC_IDLE;
    endcase

    // Read data one cycle after the strobe; unmapped reads give zero
    s_nxt.rdata = `NVAC_ZERO8;
    if (reg_rd) begin
      if (hit(reg_addr, `NVAC_OFF_ACCESS_CONTROL)) s_nxt.rdata = ctl_image(s_r);
      if (hit(reg_addr, `NVAC_OFF_UNLOCK_PORT))    s_nxt.rdata = `NVAC_ZERO8;
      if (hit(reg_addr, `NVAC_OFF_ADDR_LOW))       s_nxt.rdata = s_r.addr_lo;
      if (hit(reg_addr, `NVAC_OFF_ADDR_HIGH))      s_nxt.rdata = s_r.addr_hi;
      if (hit(reg_addr, `NVAC_OFF_DATA_LOW))       s_nxt.rdata = s_r.data_lo;
      if (hit(reg_addr, `NVAC_OFF_DATA_HIGH))      s_nxt.rdata = s_r.data_hi;
      if (hit(reg_addr, `NVAC_OFF_STATUS))         s_nxt.rdata = {7'h00, s_r.done};
    end

    // Filtered warm reset cutting a write short flags the abort; data, address, space keep
    if (warm_hit) begin
      s_nxt.abort  = (s_r.st == nvac_pkg::NVAC_EEWR) || (s_r.st == nvac_pkg::NVAC_FLWR)
                     || s_r.abort;
      s_nxt.st     = nvac_pkg::NVAC_IDLE;
      s_nxt.ul     = nvac_pkg::NVAC_LOCK0;
      s_nxt.wr     = 1'b0;
      s_nxt.rd     = 1'b0;
      s_nxt.permit = 1'b0;
      s_nxt.stall  = 1'b0;
      s_nxt.mem_we = 1'b0;
    end
  end

  // Full reset clears everything; abort_rst is the warm reset that keeps data
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state record
  assign reg_rdata = s_r.rdata;
  assign mem_we    = s_r.mem_we;
  assign mem_space = s_r.mem_space;
  assign mem_addr  = s_r.mem_addr;
  assign mem_wdata = s_r.mem_wdata;
  assign cpu_stall = s_r.stall;

endmodule

// ==== nvac_ctrl_monitor.sv ====
// Port checker for the memory access controller.
// Assumes it is bound to nvac_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`include "nvac_cfg.svh"
module nvac_ctrl_monitor #(
  parameter logic [15:0] EE_WR_CYCLES = `NVAC_EE_WR_CYCLES
) (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        abort_rst,
  input wire logic [8:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        flash_store_permit_cfg,
  input wire logic        flash_protected,
  input wire logic [7:0]  ee_rdata,
  input wire logic [13:0] fl_rdata,
  input wire logic        mem_we,
  input wire logic        mem_space,
  input wire logic [12:0] mem_addr,
  input wire logic [13:0] mem_wdata,
  input wire logic        cpu_stall
);
  // Warm reset cuts accesses short, so its cycles are excused
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn || abort_rst);
  stall_two_a: assert property ($rose(cpu_stall) |=> cpu_stall ##1 !cpu_stall)
    else $error("stall not two cycles");
  stall_end_a: assert property ($fell(cpu_stall) |-> mem_we && mem_space)
    else $error("stall ended without flash store");
  flash_gate_a: assert property ($rose(cpu_stall) |-> $past(flash_store_permit_cfg) && !$past(flash_protected))
    else $error("flash store while barred");
  flash_space_a: assert property ($rose(cpu_stall) |-> mem_space)
    else $error("stall outside flash space");
  store_pulse_a: assert property (mem_we |=> !mem_we)
    else $error("store pulse too long");
  target_hold_a: assert property (mem_we |-> $stable(mem_addr) && $stable(mem_wdata))
    else $error("store target moved");
  port_zero_a: assert property (reg_rd && reg_addr == `NVAC_OFF_UNLOCK_PORT |=> reg_rdata == 8'h00)
    else $error("unlock port not zero");
  ctrl_gap_a: assert property (reg_rd && reg_addr == `NVAC_OFF_ACCESS_CONTROL |=> reg_rdata[6:4] == 3'h0)
    else $error("control gap bits set");
  data_top_a: assert property (reg_rd && reg_addr == `NVAC_OFF_DATA_HIGH |=> reg_rdata[7:6] == 2'h0)
    else $error("data high top bits set");
  // Main scenarios reached
  cover property ($rose(cpu_stall));
  cover property (mem_we && !mem_space);
  cover property (reg_rd && reg_addr == `NVAC_OFF_UNLOCK_PORT);
endmodule
bind nvac_ctrl nvac_ctrl_monitor #(.EE_WR_CYCLES(EE_WR_CYCLES)) u_mon (
  .core_clk(core_clk), .rstn(rstn), .abort_rst(abort_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .flash_store_permit_cfg(flash_store_permit_cfg), .flash_protected(flash_protected),
  .ee_rdata(ee_rdata), .fl_rdata(fl_rdata), .mem_we(mem_we), .mem_space(mem_space),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .cpu_stall(cpu_stall));

// ==== test_nvac_ctrl.sv ====
// Self-checking bench for the memory access controller.
// Assumes the bench plays firmware at the registers and the memory arrays.
`timescale 1ns/1ps
`include "nvac_cfg.svh"
module test_nvac_ctrl;
  localparam logic [15:0] EEW = 16'h0008;
  localparam logic [8:0] CT = `NVAC_OFF_ACCESS_CONTROL;
  localparam logic [8:0] UP = `NVAC_OFF_UNLOCK_PORT;
  localparam logic [7:0] TP [4] = '{8'h00, 8'h00, 8'h04, 8'h04};
  localparam logic [7:0] T1 [4] = '{8'h55, 8'h55, 8'haa, 8'h55};
  localparam logic [7:0] T2 [4] = '{8'haa, 8'haa, 8'h55, 8'h55};
  localparam logic [7:0] TT [4] = '{8'h06, 8'h02, 8'h06, 8'h06};
  localparam logic [7:0] TX [4] = '{8'h04, 8'h00, 8'h04, 8'h04};
  logic        core_clk = 1'b0, rstn = 1'b0, abort_rst = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, fl_cfg = 1'b0, fl_prot = 1'b0;
  logic [8:0]  reg_addr = 9'h000;
  logic [7:0]  reg_wdata = 8'h00, ee_rdata = 8'h00, reg_rdata;
  logic [13:0] fl_rdata = 14'h0000, mem_wdata;
  logic [12:0] mem_addr;
  logic        mem_we, mem_space, cpu_stall;
  int          n_fail = 0, samples_checked = 0, cyc = 0, n;
  nvac_ctrl #(.EE_WR_CYCLES(EEW)) dut (
    .core_clk(core_clk), .rstn(rstn), .abort_rst(abort_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_store_permit_cfg(fl_cfg), .flash_protected(fl_prot), .ee_rdata(ee_rdata),
    .fl_rdata(fl_rdata), .mem_we(mem_we), .mem_space(mem_space), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .cpu_stall(cpu_stall));
  // 100 MHz clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Hang limit, far above the roughly 125 cycles the tests need
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Strobe stays up after a write; the next rd or idle drops it, a following wr keeps it up
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    chk($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic idle(input int k);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (k) @(posedge core_clk);
  endtask
  task automatic unl(input logic [7:0] c);
    wr(UP, 8'h55);
    wr(UP, 8'haa);
    wr(CT, c);
  endtask
  // Edges from call until the store pulse is seen; stalled edges counted alongside
  task automatic wait_we(input logic [7:0] e, input logic [7:0] s);
    int k;
    k = 0;
    idle(0);
    for (n = 1; n < 40; n++) begin
      @(posedge core_clk);
      if (cpu_stall === 1'b1) k++;
      if (mem_we === 1'b1) break;
    end
    chk("store delay", n[15:0], {8'h00, e});
    chk("stall cycles", k[15:0], {8'h00, s});
  endtask
  // Test sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    rd(CT, 8'h00);
    wr(UP, 8'hff);
    rd(UP, 8'h00);
    $display("test reset done");
    wr(`NVAC_OFF_ADDR_LOW, 8'h21);
    ee_rdata <= 8'hc3;
    wr(CT, 8'h01);
    rd(`NVAC_OFF_DATA_LOW, 8'hc3);
    ee_rdata <= 8'h00;
    rd(CT, 8'h00);
    rd(`NVAC_OFF_DATA_LOW, 8'hc3);
    $display("test byte read done");
    wr(`NVAC_OFF_ADDR_HIGH, 8'h12);
    wr(CT, 8'h80);
    fl_rdata <= 14'h3abc;
    wr(CT, 8'h81);
    wr(CT, 8'h01);
    idle(2);
    rd(`NVAC_OFF_DATA_LOW, 8'hbc);
    rd(`NVAC_OFF_DATA_HIGH, 8'h3a);
    rd(CT, 8'h80);
    $display("test word read done");
    for (int i = 0; i < 4; i++) begin
      wr(CT, TP[i]);
      wr(UP, T1[i]);
      wr(UP, T2[i]);
      wr(CT, TT[i]);
      rd(CT, TX[i]);
      rd(`NVAC_OFF_STATUS, 8'h00);
    end
    $display("test refusals done");
    wr(CT, 8'h04);
    unl(8'h06);
    reg_wr <= 1'b0;
    // Held three edges so the pin filter sees it; two more edges for it to act
    abort_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    abort_rst <= 1'b0;
    idle(2);
    rd(CT, 8'h08);
    $display("test abort done");
    wr(`NVAC_OFF_ADDR_LOW, 8'h33);
    wr(`NVAC_OFF_DATA_LOW, 8'h99);
    // Abort flag left set so that completion must be the one to clear it
    wr(CT, 8'h0c);
    unl(8'h0e);
    wr(CT, 8'h08);
    rd(CT, 8'h0a);
    wait_we(EEW[7:0] - 8'h02, 8'h00);
    chk("byte target", {mem_wdata[7:0], mem_addr[7:0]}, 16'h9933);
    chk("byte space", {15'h0000, mem_space}, 16'h0000);
    rd(CT, 8'h00);
    rd(`NVAC_OFF_STATUS, 8'h01);
    wr(`NVAC_OFF_STATUS, 8'h00);
    rd(`NVAC_OFF_STATUS, 8'h00);
    $display("test byte write done");
    wr(`NVAC_OFF_ADDR_LOW, 8'h44);
    wr(`NVAC_OFF_DATA_LOW, 8'h55);
    wr(`NVAC_OFF_DATA_HIGH, 8'h2b);
    for (int i = 0; i < 3; i++) begin
      fl_cfg <= (i != 0);
      fl_prot <= (i == 1);
      wr(CT, 8'h84);
      unl(8'h86);
      if (i < 2) rd(CT, 8'h84);
    end
    wait_we(8'h03, 8'h02);
    chk("word data", {2'h0, mem_wdata}, 16'h2b55);
    chk("word addr", {2'h0, mem_space, mem_addr}, 16'h3244);
    rd(CT, 8'h84);
    $display("test word write done");
    idle(2);
    print_verdict();
  end
endmodule
